//--- core/chb_pkg.sv
package chb_pkg;

   // ==========================================================================
   // Timing
   // ==========================================================================
   localparam int          CLK_PERIOD_NS     = 10;
   localparam int          STROBE_SHORT_NS   = 30;
   localparam int          STROBE_MEDIUM_NS  = 50;
   localparam int          STROBE_LONG_NS    = 80;
   localparam logic [3:0]  STROBE_SHORT_CYC  = 4'((STROBE_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0]  STROBE_MEDIUM_CYC = 4'((STROBE_MEDIUM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0]  STROBE_LONG_CYC   = 4'((STROBE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ==========================================================================
   // Host address layout
   // ==========================================================================
   localparam int          ADDR_DATA_BIT   = 15;
   localparam int          ADDR_MULTI_BIT  = 14;
   localparam int          ADDR_STAT_BIT   = 13;
   localparam int          OPC_W           = 12;

   // ==========================================================================
   // Snooped opcodes and fields
   // ==========================================================================
   localparam logic [11:0] OPC_COUNT_WR    = 12'h001;
   localparam logic [11:0] OPC_SEG_CTRL_WR = 12'h002;
   localparam logic [11:0] OPC_CTRL_WR     = 12'h003;
   localparam logic [7:0]  OPC_PICK_SRC    = 8'h80;
   localparam logic [7:0]  OPC_PICK_DST    = 8'h81;
   localparam logic [3:0]  OPC_ARRAY_SEL   = 4'h4;
   localparam int          CNT_DST_LSB     = 0;
   localparam int          SEG_DST_ST_LSB  = 0;
   localparam int          SEG_DST_END_LSB = 2;
   localparam int          CTL_CAMRAM_LSB  = 0;
   localparam logic [1:0]  DST_START_RST   = 2'h0;
   localparam logic [1:0]  DST_END_RST     = 2'h3;
   localparam logic [1:0]  CAMRAM_RST      = 2'h0;
   localparam logic [1:0]  LAST_CMD_RD     = 2'h0;
   localparam logic [1:0]  LAST_DAT_RD     = 2'h1;
   localparam logic [1:0]  LAST_DAT_WR     = 2'h3;

   // ==========================================================================
   // Types
   // ==========================================================================
   typedef enum logic [1:0] {LEN_SHORT, LEN_MEDIUM, LEN_LONG} chbLen_e;
   typedef enum logic [2:0] {DEC_IDLE, DEC_LO, DEC_HI, DEC_KICK, DEC_WAIT, DEC_ACK} chbDec_e;
   typedef enum logic [2:0] {SEQ_IDLE, SEQ_LAUNCH, SEQ_CMD_WR, SEQ_CMD_RD, SEQ_DAT_RD, SEQ_DAT_WR} chbSeq_e;

   typedef struct packed {
      logic        dataCycle;
      logic        multi;
      logic        read;
      chbLen_e     len;
      logic [11:0] opcode;
   } chbReq_s;

   typedef struct packed {
      logic fullLow;
      logic multiLow;
      logic matchLow;
   } chbFlags_s;

   typedef struct packed {
      logic        beginLow;
      logic        csLow;
      logic        rw;
      logic [15:0] addr;
      logic [31:0] data;
   } chbHostIn_s;

endpackage : chb_pkg

//--- core/chb_cam_bridge.sv
// Notes on behaviour
// - Decoder classifies each access as command or data, short, medium or long.
// - Decoder registers host direction and address; address feeds the write mux.
// - Decoder drives transfer acknowledge and its tristate enable.
// - Match, multiple-match and full flags are registered at every access end.
// - Status read with address bit 13 returns flags on bits 0 to 2, rest zero.
// - Status read ignores other address bits and starts no memory access.
// - Decoder pulses cycle kick for one cycle to start a memory cycle.
// - Engine free is high whenever the sequencer idles with no access.
// - Decoder launches nothing until engine free, with the sequencer idle.
// - Engine done in the wait state leads to the host transfer acknowledge.
// - Sequencer makes memory strobes, write mux select and data bus direction.
// - Sequencer is one six-state machine, held idle in reset.
// - After a kick, launch state branches by data flag and latched direction.
// - Finished sub-sequence returns to idle, or launch if a kick is present.
// - Data write at the destination segment end is a long cycle; words are counted.
// - Segment control writes are snooped for destination start and end, count writes for the count.
// - Snooped partition bits steer the read and write muxes.
// - Source or destination array selection is remembered for data cycles.
// - Command/data select is low for command cycles, high for data cycles.
// - Bit 15 marks data; bits 11 to 0 are the opcode; 15 to 12 not forwarded.
// - Bit 14 on a command write sends opcode then low host data in two memory cycles.
// - 32-bit host data is pipelined and sent as 16-bit words.
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/10ps
`default_nettype none

module chb_cam_bridge
   import chb_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        hostXferBeginLow,
   input  wire logic        chipSelectLow,
   input  wire logic        hostReadWrite,
   input  wire logic [15:0] hostAddr,
   input  wire logic [31:0] hostDataIn,
   output logic      [31:0] hostDataOut,
   output logic             hostDataOeLow,
   output logic             hostXferAckLow,
   output logic             hostXferAckOeLow,
   output logic             camEnableLow,
   output logic             camWriteLow,
   output logic             camCmdDataSel,
   input  wire logic [15:0] camDqIn,
   output logic      [15:0] camDqOut,
   output logic             camDqOeLow,
   input  wire logic        matchFlagLow,
   input  wire logic        multiMatchLow,
   input  wire logic        fullFlagLow
);

   // ==========================================================================
   // Input synchronisers
   // ==========================================================================
   chbHostIn_s  hostRaw;
   chbHostIn_s  hostMeta_q;
   chbHostIn_s  host_q;
   chbFlags_s   flagRaw;
   chbFlags_s   flagMeta_q;
   chbFlags_s   flag_q;
   logic [15:0] dqMeta_q;
   logic [15:0] dq_q;

   assign hostRaw = '{beginLow: hostXferBeginLow, csLow: chipSelectLow, rw: hostReadWrite,
                      addr: hostAddr, data: hostDataIn};
   assign flagRaw = '{fullLow: fullFlagLow, multiLow: multiMatchLow, matchLow: matchFlagLow};

   // Every pin but clock and reset, the host bus included, is treated as foreign; the two-cycle
   // lag keeps the relative timing of address and data phases intact.
   always_ff @(posedge clk)
   begin
      hostMeta_q <= hostRaw;
      host_q     <= hostMeta_q;
      flagMeta_q <= flagRaw;
      flag_q     <= flagMeta_q;
      dqMeta_q   <= camDqIn;
      dq_q       <= dqMeta_q;
   end

   // ==========================================================================
   // Decoder
   // ==========================================================================
   chbDec_e     decState_q;
   chbReq_s     req_q;
   chbReq_s     reqNew;
   logic [63:0] wrData_q;
   logic [31:0] rdData_q;
   logic [31:0] rdMerged;
   logic [31:0] hostDataOut_q;
   chbFlags_s   status_q;
   logic        statusRd_q;
   logic        srcArr_q;
   logic        dstArr_q;
   logic        accept;
   logic        statusRd;
   logic        cycleKick;
   logic        engineFree;
   logic        engineDone;

   assign accept   = (decState_q == DEC_IDLE) && !host_q.beginLow && !host_q.csLow;
   assign statusRd = host_q.addr[ADDR_STAT_BIT] && host_q.rw;
   assign cycleKick = (decState_q == DEC_KICK) && engineFree;

   always_comb
   begin
      reqNew.dataCycle = host_q.addr[ADDR_DATA_BIT];
      reqNew.multi     = host_q.addr[ADDR_MULTI_BIT];
      reqNew.read      = host_q.rw;
      reqNew.opcode    = host_q.addr[OPC_W-1:0];
      if (!reqNew.dataCycle)
         reqNew.len = reqNew.read ? LEN_MEDIUM : LEN_SHORT;
      else if (reqNew.read)
         reqNew.len = srcArr_q ? LEN_LONG : LEN_MEDIUM;
      else
         reqNew.len = LEN_MEDIUM;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         decState_q <= DEC_IDLE;
      else
      begin
         case (decState_q)
            DEC_IDLE:
               if (accept)
               begin
                  if (statusRd)
                     decState_q <= DEC_ACK;
                  else if (!host_q.rw)
                     decState_q <= DEC_LO;
                  else
                     decState_q <= DEC_KICK;
               end
            DEC_LO:
               decState_q <= req_q.dataCycle ? DEC_HI : DEC_KICK;
            DEC_HI:
               decState_q <= DEC_KICK;
            DEC_KICK:
               if (engineFree)
                  decState_q <= DEC_WAIT;
            DEC_WAIT:
               if (engineDone)
                  decState_q <= DEC_ACK;
            DEC_ACK:
               decState_q <= DEC_IDLE;
            default:
               decState_q <= DEC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         req_q      <= '0;
         statusRd_q <= 1'b0;
      end
      else if (accept)
      begin
         statusRd_q <= statusRd;
         if (!statusRd)
            req_q <= reqNew;
      end
   end

   // The second data phase arrives one cycle after the first.
   always_ff @(posedge clk)
   begin
      if (reset)
         wrData_q <= '0;
      else if (decState_q == DEC_LO)
         wrData_q[31:0] <= host_q.data;
      else if (decState_q == DEC_HI)
         wrData_q[63:32] <= host_q.data;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         hostDataOut_q <= '0;
      else if (accept && statusRd)
         hostDataOut_q <= {29'h0, status_q};
      else if (decState_q == DEC_WAIT && engineDone && req_q.read)
         hostDataOut_q <= rdMerged;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         srcArr_q <= 1'b0;
         dstArr_q <= 1'b0;
      end
      else if (cycleKick && !req_q.dataCycle && !req_q.read)
      begin
         if (req_q.opcode[11:4] == OPC_PICK_SRC)
            srcArr_q <= (req_q.opcode[3:0] == OPC_ARRAY_SEL);
         if (req_q.opcode[11:4] == OPC_PICK_DST)
            dstArr_q <= (req_q.opcode[3:0] == OPC_ARRAY_SEL);
      end
   end

   assign hostXferAckLow   = !(decState_q == DEC_ACK);
   assign hostXferAckOeLow = (decState_q == DEC_IDLE);
   assign hostDataOeLow    = !((decState_q == DEC_ACK) && (statusRd_q || req_q.read));
   assign hostDataOut      = hostDataOut_q;

   // ==========================================================================
   // Strobe sequencer
   // ==========================================================================
   chbSeq_e     seqState_q;
   logic [1:0]  wordIdx_q;
   logic [3:0]  strobeCnt_q;
   logic        camEnableLow_q;
   logic        camWriteLow_q;
   logic        camCmdDataSel_q;
   logic [15:0] camDqOut_q;
   logic [1:0]  wrSel_q;
   logic [1:0]  dstStart_q;
   logic [1:0]  dstEnd_q;
   logic [1:0]  dstCnt_q;
   logic [1:0]  camRam_q;
   logic [1:0]  lastIdx;
   logic        inAccess;
   logic        gap;
   logic        wordLast;
   logic        isWrite;
   logic        lastDst;
   logic [1:0]  nextIdx;
   logic [1:0]  nextSel;
   logic [3:0]  nextLen;
   logic [15:0] nextWord;

   function automatic logic [3:0] lenCycles(input chbLen_e len);
      case (len)
         LEN_SHORT:  lenCycles = STROBE_SHORT_CYC;
         LEN_MEDIUM: lenCycles = STROBE_MEDIUM_CYC;
         LEN_LONG:   lenCycles = STROBE_LONG_CYC;
         default:    lenCycles = STROBE_LONG_CYC;
      endcase
   endfunction : lenCycles

   assign inAccess = (seqState_q == SEQ_CMD_WR) || (seqState_q == SEQ_CMD_RD) ||
                     (seqState_q == SEQ_DAT_RD) || (seqState_q == SEQ_DAT_WR);
   assign gap      = inAccess && camEnableLow_q;
   assign isWrite  = !req_q.read;
   assign lastDst  = dstArr_q && (dstCnt_q == dstEnd_q);

   always_comb
   begin
      case (seqState_q)
         SEQ_CMD_WR: lastIdx = {1'b0, req_q.multi};
         SEQ_DAT_RD: lastIdx = LAST_DAT_RD;
         SEQ_DAT_WR: lastIdx = LAST_DAT_WR;
         default:    lastIdx = LAST_CMD_RD;
      endcase
   end

   assign wordLast   = wordIdx_q == lastIdx;
   assign engineDone = gap && wordLast;
   assign engineFree = (seqState_q == SEQ_IDLE);
   assign nextIdx    = (seqState_q == SEQ_LAUNCH) ? 2'h0 : 2'(wordIdx_q + 2'h1);
   assign nextSel    = req_q.dataCycle ? 2'(nextIdx + camRam_q) : nextIdx;
   assign nextLen    = (req_q.dataCycle && isWrite && lastDst) ? lenCycles(LEN_LONG)
                                                               : lenCycles(req_q.len);

   always_comb
   begin
      if (!req_q.dataCycle)
         nextWord = nextIdx[0] ? wrData_q[15:0] : {4'h0, req_q.opcode};
      else
         nextWord = wrData_q[16*nextSel +: 16];
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         seqState_q <= SEQ_IDLE;
      else
      begin
         case (seqState_q)
            SEQ_IDLE:
               if (cycleKick)
                  seqState_q <= SEQ_LAUNCH;
            SEQ_LAUNCH:
               case ({req_q.dataCycle, req_q.read})
                  2'b00:   seqState_q <= SEQ_CMD_WR;
                  2'b01:   seqState_q <= SEQ_CMD_RD;
                  2'b11:   seqState_q <= SEQ_DAT_RD;
                  default: seqState_q <= SEQ_DAT_WR;
               endcase
            SEQ_CMD_WR, SEQ_CMD_RD, SEQ_DAT_RD, SEQ_DAT_WR:
               if (engineDone)
                  seqState_q <= cycleKick ? SEQ_LAUNCH : SEQ_IDLE;
            default:
               seqState_q <= SEQ_IDLE;
         endcase
      end
   end

   // One strobe per word, followed by one recovery cycle with the bus idle.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         wordIdx_q      <= '0;
         strobeCnt_q    <= '0;
         camEnableLow_q <= 1'b1;
         camWriteLow_q  <= 1'b1;
         camDqOut_q     <= '0;
         wrSel_q        <= '0;
      end
      else if ((seqState_q == SEQ_LAUNCH) || (gap && !wordLast))
      begin
         wordIdx_q      <= nextIdx;
         strobeCnt_q    <= nextLen;
         camEnableLow_q <= 1'b0;
         camWriteLow_q  <= !isWrite;
         camDqOut_q     <= nextWord;
         wrSel_q        <= nextSel;
      end
      else if (inAccess && !camEnableLow_q)
      begin
         strobeCnt_q <= 4'(strobeCnt_q - 4'h1);
         if (strobeCnt_q == 4'h1)
         begin
            camEnableLow_q <= 1'b1;
            camWriteLow_q  <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         camCmdDataSel_q <= 1'b0;
      else if (seqState_q == SEQ_LAUNCH)
         camCmdDataSel_q <= req_q.dataCycle;
   end

   // Read data is sampled in the recovery cycle, so the strobe must cover the
   // memory access time plus the two-flop lag of the data input.
   // The last word lands at the same edge that hands the data to the host,
   // so the host register takes the merged value rather than the old one.
   always_comb
   begin
      rdMerged = rdData_q;
      if (wordIdx_q[0] ^ (req_q.dataCycle & camRam_q[0]))
         rdMerged[31:16] = dq_q;
      else
         rdMerged[15:0] = dq_q;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         rdData_q <= '0;
      else if (gap && req_q.read)
         rdData_q <= rdMerged;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         status_q <= '1;
      else if (engineDone)
         status_q <= flag_q;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         dstStart_q <= DST_START_RST;
         dstEnd_q   <= DST_END_RST;
         dstCnt_q   <= DST_START_RST;
         camRam_q   <= CAMRAM_RST;
      end
      else if (cycleKick && !req_q.dataCycle && !req_q.read && req_q.multi)
      begin
         if (req_q.opcode == OPC_SEG_CTRL_WR)
         begin
            dstStart_q <= wrData_q[SEG_DST_ST_LSB +: 2];
            dstEnd_q   <= wrData_q[SEG_DST_END_LSB +: 2];
            dstCnt_q   <= wrData_q[SEG_DST_ST_LSB +: 2];
         end
         if (req_q.opcode == OPC_COUNT_WR)
            dstCnt_q <= wrData_q[CNT_DST_LSB +: 2];
         if (req_q.opcode == OPC_CTRL_WR)
            camRam_q <= wrData_q[CTL_CAMRAM_LSB +: 2];
      end
      // The counter holds the index of the word being loaded, so the compare
      // judges the word about to be written, not the one just finished.
      else if (dstArr_q && req_q.dataCycle && isWrite &&
               ((seqState_q == SEQ_LAUNCH) || (gap && !wordLast && (seqState_q == SEQ_DAT_WR))))
         dstCnt_q <= lastDst ? dstStart_q : 2'(dstCnt_q + 2'h1);
   end

   assign camEnableLow  = camEnableLow_q;
   assign camWriteLow   = camWriteLow_q;
   assign camCmdDataSel = camCmdDataSel_q;
   assign camDqOut      = camDqOut_q;
   assign camDqOeLow    = camWriteLow_q;

   // ==========================================================================
   // Assertions
   // ==========================================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_kick_one_cycle: assert property (cycleKick |=> !cycleKick)
      else $error("cycle kick longer than one cycle");
   a_free_no_strobe: assert property (engineFree |-> camEnableLow)
      else $error("strobe active while engine free");
   a_kick_gated: assert property (cycleKick |-> engineFree && seqState_q == SEQ_IDLE)
      else $error("kick while engine busy");
   a_done_to_ack: assert property (engineDone |=> !hostXferAckLow && !hostXferAckOeLow)
      else $error("no acknowledge after engine done");
   a_dq_release: assert property (!camDqOeLow |-> !camEnableLow && isWrite)
      else $error("data bus driven outside write strobe");
   a_status_bits: assert property (accept && statusRd |=> ##0 (decState_q == DEC_ACK)
                                   ##0 hostDataOut[31:3] == 29'h0 && hostDataOut[2:0] == $past(status_q))
      else $error("quick status read data wrong");
   a_status_no_mem: assert property (accept && statusRd && engineFree |=> engineFree [*2])
      else $error("status read started a memory access");
   a_launch_follow: assert property (cycleKick |=> seqState_q == SEQ_LAUNCH ##1 inAccess)
      else $error("kick did not launch a cycle");
   a_cmd_sel: assert property (!camEnableLow |-> camCmdDataSel == req_q.dataCycle)
      else $error("command/data select wrong during strobe");
   a_long_last: assert property ((seqState_q == SEQ_LAUNCH) && req_q.dataCycle && isWrite && lastDst
                                 |=> strobeCnt_q == STROBE_LONG_CYC)
      else $error("last data write not a long cycle");
   a_strobe_width: assert property ($fell(camEnableLow) && strobeCnt_q == STROBE_SHORT_CYC
                                    |-> !camEnableLow [*3] ##1 camEnableLow)
      else $error("short strobe width wrong");

endmodule : chb_cam_bridge

`default_nettype wire

//--- test/chb_cam_model.sv
`timescale 1ns/10ps
`default_nettype none

module chb_cam_model
   import chb_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        camEnableLow,
   input  wire logic        camWriteLow,
   input  wire logic        camCmdDataSel,
   input  wire logic [15:0] camDqOut,
   input  wire logic        camDqOeLow,
   output logic      [15:0] camDqIn
);
   // ==========================================================================
   // Access log
   // ==========================================================================
   logic [15:0] logWord [0:31];
   logic        logSel  [0:31];
   logic        logWr   [0:31];
   int          logLen  [0:31];
   int          logCnt  = 0;
   int          runLen  = 0;

   initial camDqIn = 16'h0F0F;

   // Outside a read strobe the bus toggles every cycle, so a late sample cannot pass by luck.
   always @(posedge clk)
   begin
      camDqIn <= (!camEnableLow && camWriteLow) ? {8'hC3, logCnt[7:0]} : ~camDqIn;
      if (!camEnableLow)
      begin
         runLen++;
         logWord[logCnt[4:0]] = camWriteLow ? camDqIn : camDqOut;
         logSel[logCnt[4:0]]  = camCmdDataSel;
         logWr[logCnt[4:0]]   = !camDqOeLow;
      end
      else if (runLen != 0)
      begin
         logLen[logCnt[4:0]] = runLen;
         logCnt++;
         runLen = 0;
      end
   end
endmodule : chb_cam_model

`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end

module tb_top
   import chb_pkg::*;
;
   logic        clk = 1'b0;
   logic        reset, hostXferBeginLow, chipSelectLow, hostReadWrite;
   logic [15:0] hostAddr, camDqIn, camDqOut;
   logic [31:0] hostDataIn, hostDataOut, rd;
   logic        hostDataOeLow, hostXferAckLow, hostXferAckOeLow;
   logic        camEnableLow, camWriteLow, camCmdDataSel, camDqOeLow;
   chbFlags_s   flagReg;
   int          err_total = 0;
   int          tests_run = 0;
   int          base;

   always #5 clk = ~clk;

   chb_cam_bridge uut (.clk(clk), .reset(reset), .hostXferBeginLow(hostXferBeginLow),
      .chipSelectLow(chipSelectLow), .hostReadWrite(hostReadWrite), .hostAddr(hostAddr),
      .hostDataIn(hostDataIn), .hostDataOut(hostDataOut), .hostDataOeLow(hostDataOeLow),
      .hostXferAckLow(hostXferAckLow), .hostXferAckOeLow(hostXferAckOeLow),
      .camEnableLow(camEnableLow), .camWriteLow(camWriteLow), .camCmdDataSel(camCmdDataSel),
      .camDqIn(camDqIn), .camDqOut(camDqOut), .camDqOeLow(camDqOeLow),
      .matchFlagLow(flagReg.matchLow), .multiMatchLow(flagReg.multiLow), .fullFlagLow(flagReg.fullLow));

   chb_cam_model cam (.clk(clk), .camEnableLow(camEnableLow), .camWriteLow(camWriteLow),
      .camCmdDataSel(camCmdDataSel), .camDqOut(camDqOut), .camDqOeLow(camDqOeLow), .camDqIn(camDqIn));

   // ==========================================================================
   // Tasks
   // ==========================================================================
   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : complete_run

   // Called just after a rising edge; begin is pulsed for one cycle, chip select is held low until the acknowledge is seen.
   task automatic host_access(input logic rw, input logic [15:0] a, input logic [31:0] d0, d1);
      int i;
      hostXferBeginLow <= 1'b0;
      chipSelectLow    <= 1'b0;
      hostReadWrite    <= rw;
      hostAddr         <= a;
      hostDataIn       <= d0;
      @(posedge clk);
      hostXferBeginLow <= 1'b1;
      @(posedge clk);
      hostDataIn       <= d1;
      for (i = 0; i < 200; i++)
      begin
         @(posedge clk);
         if (hostXferAckLow === 1'b0)
            break;
      end
      if (i == 200)
      begin
         err_total++;
         complete_run();
      end
      `CHK("ackEnable", 1'b0, hostXferAckOeLow)
      `CHK("dataEnable", ~rw, hostDataOeLow)
      rd = hostDataOut;
      chipSelectLow <= 1'b1;
      hostDataIn    <= ~d1;
      @(posedge clk);
   endtask : host_access

   task automatic chk_mem(input int idx, input logic [15:0] w, input logic s, input logic wr);
      `CHK("memWord", w, cam.logWord[idx[4:0]])
      `CHK("memSel", s, cam.logSel[idx[4:0]])
      `CHK("memWrite", wr, cam.logWr[idx[4:0]])
   endtask : chk_mem

   // ==========================================================================
   // Sequence
   // ==========================================================================
   initial
   begin
      reset = 1'b1; hostXferBeginLow = 1'b1; chipSelectLow = 1'b1; hostReadWrite = 1'b1;
      hostAddr = 16'h0000; hostDataIn = 32'h0000_0000; flagReg = 3'b111;
      repeat (6) @(posedge clk);
      `CHK("resetAck", 1'b1, hostXferAckLow)
      `CHK("resetEnable", 1'b1, camEnableLow)
      reset <= 1'b0;
      @(posedge clk);
      base = cam.logCnt;
      host_access(1'b0, 16'h10A5, 32'h0, 32'h0);
      chk_mem(base, 16'h00A5, 1'b0, 1'b1);
      `CHK("shortLen", 3, cam.logLen[base])
      host_access(1'b0, 16'h4123, 32'h0000_BEEF, 32'h0);
      chk_mem(base + 1, 16'h0123, 1'b0, 1'b1);
      chk_mem(base + 2, 16'hBEEF, 1'b0, 1'b1);
      flagReg <= 3'b010;
      host_access(1'b1, 16'h0211, 32'h0, 32'h0);
      chk_mem(base + 3, {8'hC3, 8'(base + 3)}, 1'b0, 1'b0);
      `CHK("mediumLen", 5, cam.logLen[base + 3])
      flagReg <= 3'b101;
      host_access(1'b1, 16'hAFFF, 32'h0, 32'h0);
      `CHK("status", 32'h0000_0002, rd)
      `CHK("statusNoAccess", base + 4, cam.logCnt)
      host_access(1'b0, 16'h0814, 32'h0, 32'h0);
      host_access(1'b0, 16'h8000, 32'h2222_1111, 32'h4444_3333);
      for (int k = 0; k < 4; k++)
         chk_mem(base + 5 + k, {4{4'(k + 1)}}, 1'b1, 1'b1);
      `CHK("lastWordLong", 8, cam.logLen[base + 8])
      host_access(1'b1, 16'h8000, 32'h0, 32'h0);
      `CHK("dataRead", {8'hC3, 8'(base + 10), 8'hC3, 8'(base + 9)}, rd)
      `CHK("readCount", base + 11, cam.logCnt)
      host_access(1'b0, 16'h4002, 32'h0000_0004, 32'h0);
      host_access(1'b0, 16'h8000, 32'h2222_1111, 32'h4444_3333);
      `CHK("segLong1", 8, cam.logLen[base + 14])
      `CHK("segMedium", 5, cam.logLen[base + 15])
      `CHK("segLong3", 8, cam.logLen[base + 16])
      host_access(1'b0, 16'h4001, 32'h0000_0001, 32'h0);
      host_access(1'b0, 16'h4003, 32'h0000_0001, 32'h0);
      host_access(1'b0, 16'h8000, 32'h2222_1111, 32'h4444_3333);
      chk_mem(base + 21, 16'h2222, 1'b1, 1'b1);
      `CHK("countLong", 8, cam.logLen[base + 21])
      host_access(1'b0, 16'h0804, 32'h0, 32'h0);
      host_access(1'b1, 16'h8000, 32'h0, 32'h0);
      `CHK("srcLong", 8, cam.logLen[base + 26])
      `CHK("swapRead", {8'hC3, 8'(base + 26), 8'hC3, 8'(base + 27)}, rd)
      complete_run();
   end
endmodule : tb_top

`default_nettype wire
